// [rtl/rsso_pkg.sv]
// shared constants for the rotate/subtract/swap/sleep datapath
`default_nettype none
package rsso_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int AXI_AW = 8;
    localparam int OP_W = 4;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [AXI_AW-1:0] REG_CMD = 8'h00;
    localparam logic [AXI_AW-1:0] REG_ACC = 8'h04;
    localparam logic [AXI_AW-1:0] REG_STATUS = 8'h08;
    localparam logic [AXI_AW-1:0] REG_FPTR = 8'h0c;
    localparam logic [AXI_AW-1:0] REG_FDATA = 8'h10;
    localparam logic [AXI_AW-1:0] REG_WDT = 8'h14;
    // ------------------------------------------------------------
    // command word fields
    // ------------------------------------------------------------
    localparam int CMD_LIT_LSB = 0;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_DEST_BIT = 15;
    localparam int CMD_OP_LSB = 16;
    localparam logic [3:0] CMD_STRB_NEED = 4'h7;
    // ------------------------------------------------------------
    // operation codes
    // ------------------------------------------------------------
    localparam logic [OP_W-1:0] OP_ROT_R = 4'h1;
    localparam logic [OP_W-1:0] OP_ROT_L = 4'h2;
    localparam logic [OP_W-1:0] OP_LIT_SUB = 4'h3;
    localparam logic [OP_W-1:0] OP_REG_SUB = 4'h4;
    localparam logic [OP_W-1:0] OP_BRW_SUB = 4'h5;
    localparam logic [OP_W-1:0] OP_NIB_SWAP = 4'h6;
    localparam logic [OP_W-1:0] OP_SLEEP = 4'h7;
    // ------------------------------------------------------------
    // status bits and reset values
    // ------------------------------------------------------------
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_PWRDN = 3;
    localparam int ST_TO = 4;
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [DATA_W-1:0] FILE_RST = 8'h00;
    localparam logic TO_RST = 1'b1;
    localparam logic PWRDN_RST = 1'b1;
    localparam logic DEST_ACC = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// [rtl/rsso_alu.sv]
// combinational rotate, subtract and swap unit
`default_nettype none
module rsso_alu import rsso_pkg::*; (
    input wire logic [OP_W-1:0] op,
    input wire logic [DATA_W-1:0] fval,
    input wire logic [DATA_W-1:0] lit,
    input wire logic [DATA_W-1:0] acc,
    input wire logic carry,
    output logic [DATA_W-1:0] res,
    output logic c_out,
    output logic dc_out,
    output logic z_out,
    output logic c_we,
    output logic dcz_we,
    output logic to_acc
);
    // ------------------------------------------------------------
    // subtraction as a plus inverted b plus carry-in
    // ------------------------------------------------------------
    logic is_sub;
    logic [DATA_W-1:0] sub_a;
    logic sub_cin;
    logic [DATA_W:0] sum9;
    logic [4:0] sum5;
    assign is_sub = (op == OP_LIT_SUB) || (op == OP_REG_SUB)
                 || (op == OP_BRW_SUB);
    assign sub_a = (op == OP_LIT_SUB) ? lit : fval;
    // borrow is the inverted carry, so carry feeds in directly
    assign sub_cin = (op == OP_BRW_SUB) ? carry : 1'b1;
    assign sum9 = {1'b0, sub_a} + {1'b0, ~acc} + {8'h00, sub_cin};
    assign sum5 = {1'b0, sub_a[3:0]} + {1'b0, ~acc[3:0]} + {4'h0, sub_cin};
    // ------------------------------------------------------------
    // result and flag selection
    // ------------------------------------------------------------
    assign res = is_sub ? sum9[DATA_W-1:0]
               : (op == OP_ROT_R) ? {carry, fval[7:1]}
               : (op == OP_ROT_L) ? {fval[6:0], carry}
               : {fval[3:0], fval[7:4]};
    // no-borrow carry: 1 when acc <= minuend
    assign c_out = is_sub ? sum9[DATA_W]
                 : (op == OP_ROT_R) ? fval[0] : fval[7];
    assign dc_out = sum5[4];
    assign z_out = (sum9[DATA_W-1:0] == 8'h00);
    assign c_we = is_sub || (op == OP_ROT_R) || (op == OP_ROT_L);
    assign dcz_we = is_sub;
    assign to_acc = (op == OP_LIT_SUB);
endmodule
`default_nettype wire

// [rtl/rsso_core.sv]
// datapath core with axi4-lite register access
// How it works
// - rotate right: bit0 to carry, old carry into bit7, carry only
// - dest selector 0 writes accumulator, 1 writes the file register
// - sleep clears watchdog and prescaler, sets timeout, clears powerdown
// - literal minus accumulator always lands in accumulator, sets c/dc/z
// - literal form: carry/digit carry 0 when accumulator exceeds literal
// - register minus accumulator, routed by selector, updates c/dc/z
// - register form: carry/digit carry 0 when accumulator exceeds register
// - register minus accumulator minus inverted carry, routed, sets c/dc/z
// - nibble exchange swaps halves of the register, flags untouched
// - rotate left: bit7 to carry, old carry into bit0, routed
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`default_nettype none
module rsso_core import rsso_pkg::*; #(
    parameter int PRE_W = 5,
    parameter int WDT_W = 8
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [AXI_AW-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [AXI_AW-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    function automatic logic reg_hit(input logic [AXI_AW-1:0] a);
        reg_hit = (a == REG_CMD) || (a == REG_ACC) || (a == REG_STATUS)
               || (a == REG_FPTR) || (a == REG_FDATA) || (a == REG_WDT);
    endfunction
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_pipe_q;
    logic rst_n_q;
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_pipe_q <= 2'b00;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end
    assign rst_n_q = rst_pipe_q[1];
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [DATA_W-1:0] acc_q, file_q [2**FADDR_W];
    logic c_q, dc_q, z_q, to_q, pwrdn_q, wr_rdy_q, bvalid_q, ar_rdy_q;
    logic rvalid_q;
    logic [FADDR_W-1:0] fptr_q;
    logic [PRE_W-1:0] pre_q;
    logic [WDT_W-1:0] wdt_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    // ------------------------------------------------------------
    // write decode and command fields
    // ------------------------------------------------------------
    logic wr_go, op_ok, exec, cmd_dest, wr_acc, wr_st, wr_fptr, wr_fdata;
    logic exec_sleep, file_we, acc_from_alu;
    logic [OP_W-1:0] cmd_op;
    logic [FADDR_W-1:0] cmd_addr, file_wa;
    logic [DATA_W-1:0] cmd_lit, fval, alu_res, file_wd;
    logic alu_c, alu_dc, alu_z, alu_cwe, alu_dczwe, alu_to_acc;
    assign wr_go = wr_rdy_q && S_AXI_AWVALID && S_AXI_WVALID;
    assign cmd_op = S_AXI_WDATA[CMD_OP_LSB +: OP_W];
    assign cmd_addr = S_AXI_WDATA[CMD_ADDR_LSB +: FADDR_W];
    assign cmd_lit = S_AXI_WDATA[CMD_LIT_LSB +: DATA_W];
    assign cmd_dest = S_AXI_WDATA[CMD_DEST_BIT];
    assign op_ok = (cmd_op >= OP_ROT_R) && (cmd_op <= OP_SLEEP);
    // partial command writes are ignored to avoid half-built commands
    assign exec = wr_go && (S_AXI_AWADDR == REG_CMD) && op_ok
               && ((S_AXI_WSTRB & CMD_STRB_NEED) == CMD_STRB_NEED);
    assign exec_sleep = exec && (cmd_op == OP_SLEEP);
    assign wr_acc = wr_go && (S_AXI_AWADDR == REG_ACC) && S_AXI_WSTRB[0];
    assign wr_st = wr_go && (S_AXI_AWADDR == REG_STATUS) && S_AXI_WSTRB[0];
    assign wr_fptr = wr_go && (S_AXI_AWADDR == REG_FPTR) && S_AXI_WSTRB[0];
    assign wr_fdata = wr_go && (S_AXI_AWADDR == REG_FDATA) && S_AXI_WSTRB[0];
    assign fval = file_q[cmd_addr];
    rsso_alu u_alu (
        .op(cmd_op),
        .fval(fval),
        .lit(cmd_lit),
        .acc(acc_q),
        .carry(c_q),
        .res(alu_res),
        .c_out(alu_c),
        .dc_out(alu_dc),
        .z_out(alu_z),
        .c_we(alu_cwe),
        .dcz_we(alu_dczwe),
        .to_acc(alu_to_acc)
    );
    assign acc_from_alu = exec && !exec_sleep
                       && (alu_to_acc || cmd_dest == DEST_ACC);
    assign file_we = (exec && !exec_sleep && !alu_to_acc
                      && cmd_dest != DEST_ACC) || wr_fdata;
    assign file_wa = wr_fdata ? fptr_q : cmd_addr;
    assign file_wd = wr_fdata ? S_AXI_WDATA[DATA_W-1:0] : alu_res;
    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    for (genvar i = 0; i < 2**FADDR_W; i++) begin : g_file
        always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
            if (!rst_n_q) begin
                file_q[i] <= FILE_RST;
            end else if (file_we && file_wa == FADDR_W'(i)) begin
                file_q[i] <= file_wd;
            end
        end
    end
    // ------------------------------------------------------------
    // accumulator, flags, watchdog
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            acc_q <= ACC_RST;
            c_q <= 1'b0;
            dc_q <= 1'b0;
            z_q <= 1'b0;
            fptr_q <= '0;
        end else begin
            if (acc_from_alu) begin
                acc_q <= alu_res;
            end else if (wr_acc) begin
                acc_q <= S_AXI_WDATA[DATA_W-1:0];
            end
            if (exec && alu_cwe) begin
                c_q <= alu_c;
            end else if (wr_st) begin
                c_q <= S_AXI_WDATA[ST_C];
            end
            if (exec && alu_dczwe) begin
                dc_q <= alu_dc;
                z_q <= alu_z;
            end else if (wr_st) begin
                dc_q <= S_AXI_WDATA[ST_DC];
                z_q <= S_AXI_WDATA[ST_Z];
            end
            if (wr_fptr) begin
                fptr_q <= S_AXI_WDATA[FADDR_W-1:0];
            end
        end
    end
    // timeout and powerdown are read-only; only sleep moves them here
    always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            to_q <= TO_RST;
            pwrdn_q <= PWRDN_RST;
            pre_q <= '0;
            wdt_q <= '0;
        end else if (exec_sleep) begin
            to_q <= 1'b1;
            pwrdn_q <= 1'b0;
            pre_q <= '0;
            wdt_q <= '0;
        end else begin
            pre_q <= pre_q + PRE_W'(1);
            if (&pre_q) begin
                wdt_q <= wdt_q + WDT_W'(1);
            end
        end
    end
    // ------------------------------------------------------------
    // axi4-lite handshakes
    // ------------------------------------------------------------
    logic [31:0] rd_word;
    logic [1:0] wr_resp;
    assign wr_resp = (reg_hit(S_AXI_AWADDR)
                     && (S_AXI_AWADDR != REG_CMD || op_ok))
                     ? RESP_OKAY : RESP_SLVERR;
    assign rd_word =
        (S_AXI_ARADDR == REG_ACC) ? {24'h000000, acc_q}
      : (S_AXI_ARADDR == REG_STATUS) ? {27'h0, to_q, pwrdn_q, z_q, dc_q, c_q}
      : (S_AXI_ARADDR == REG_FPTR) ? {25'h0000000, fptr_q}
      : (S_AXI_ARADDR == REG_FDATA) ? {24'h000000, file_q[fptr_q]}
      : (S_AXI_ARADDR == REG_WDT) ? 32'(wdt_q)
      : 32'h00000000;
    always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            wr_rdy_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            wr_rdy_q <= S_AXI_AWVALID && S_AXI_WVALID && !wr_rdy_q
                        && !bvalid_q;
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_resp;
            end else if (S_AXI_BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    always_ff @(posedge CORE_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ar_rdy_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h00000000;
        end else begin
            ar_rdy_q <= S_AXI_ARVALID && !ar_rdy_q && !rvalid_q;
            if (ar_rdy_q && S_AXI_ARVALID) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_word;
                rresp_q <= reg_hit(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_RREADY) begin
                rvalid_q <= 1'b0;
            end
        end
    end
    assign S_AXI_AWREADY = wr_rdy_q;
    assign S_AXI_WREADY = wr_rdy_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_ARREADY = ar_rdy_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic x_rotr, x_rotl, x_litsub, x_regsub, x_brwsub, x_swap, f0, f7;
    assign x_rotr = exec && cmd_op == OP_ROT_R;
    assign x_rotl = exec && cmd_op == OP_ROT_L;
    assign x_litsub = exec && cmd_op == OP_LIT_SUB;
    assign x_regsub = exec && cmd_op == OP_REG_SUB;
    assign x_brwsub = exec && cmd_op == OP_BRW_SUB;
    assign x_swap = exec && cmd_op == OP_NIB_SWAP;
    assign f0 = fval[0];
    assign f7 = fval[7];
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!rst_n_q);
    a_rotr_carry: assert property (x_rotr |=> c_q == $past(f0)
        && acc_q[7] == ($past(cmd_dest) ? $past(acc_q[7]) : $past(c_q)))
        else $error("rotate right carry wrong");
    a_dest_acc: assert property (x_rotl && !cmd_dest |=> acc_q
        == {$past(fval[6:0]), $past(c_q)} && c_q == $past(f7))
        else $error("rotate left to acc wrong");
    a_sleep_state: assert property (exec_sleep |=> to_q && !pwrdn_q
        && wdt_q == '0 && pre_q == '0 && $stable(c_q) && $stable(z_q))
        else $error("sleep effects wrong");
    a_lit_sub_acc: assert property (x_litsub |=> acc_q ==
        DATA_W'($past(cmd_lit) - $past(acc_q)))
        else $error("literal subtract wrong");
    a_lit_sub_flags: assert property (x_litsub |=> c_q ==
        ($past(acc_q) <= $past(cmd_lit)) && dc_q == ($past(acc_q[3:0])
        <= $past(cmd_lit[3:0]))) else $error("literal flags wrong");
    a_reg_sub_file: assert property (x_regsub && cmd_dest |=>
        file_q[$past(cmd_addr)] == DATA_W'($past(fval) - $past(acc_q))
        && $stable(acc_q)) else $error("register subtract wrong");
    a_reg_sub_flags: assert property (x_regsub |=> c_q ==
        ($past(acc_q) <= $past(fval)) && dc_q == ($past(acc_q[3:0])
        <= $past(fval[3:0]))) else $error("register flags wrong");
    a_borrow_sub: assert property (x_brwsub && !cmd_dest |=> acc_q ==
        DATA_W'($past(fval) - $past(acc_q) - {7'h00, !$past(c_q)}))
        else $error("borrow subtract wrong");
    a_swap_nibble: assert property (x_swap && !cmd_dest |=> acc_q ==
        {$past(fval[3:0]), $past(fval[7:4])} && $stable(c_q)
        && $stable(dc_q) && $stable(z_q)) else $error("swap wrong");
    a_rotl_file: assert property (x_rotl && cmd_dest |=>
        file_q[$past(cmd_addr)] == {$past(fval[6:0]), $past(c_q)}
        && $stable(acc_q)) else $error("rotate left to file wrong");
    a_zero_flag: assert property (exec && alu_dczwe |=> z_q ==
        (acc_q == 8'h00 && $past(acc_from_alu) || !$past(acc_from_alu)
        && file_q[$past(cmd_addr)] == 8'h00))
        else $error("zero flag wrong");
    c_sleep: cover property (exec_sleep ##[1:20] wr_go);
    c_sub_zero: cover property (x_regsub && alu_z);
    c_borrow_chain: cover property (x_brwsub && !c_q ##[2:20] x_brwsub);
    c_read_back: cover property (rvalid_q && S_AXI_RREADY);
endmodule
`default_nettype wire

// [tb/rotate_subtract_swap_sleep_ops_tb_top.sv]
// register-level testbench for the rotate/subtract/swap/sleep datapath
`default_nettype none
module rotate_subtract_swap_sleep_ops_tb_top import rsso_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // stimulus signals and local op codes
    // ------------------------------------------------------------
    localparam logic [3:0] op_rot_r = 4'h1;
    localparam logic [3:0] op_rot_l = 4'h2;
    localparam logic [3:0] op_lit_sub = 4'h3;
    localparam logic [3:0] op_f_sub = 4'h4;
    localparam logic [3:0] op_sub_brw = 4'h5;
    localparam logic [3:0] op_swap = 4'h6;
    localparam logic [3:0] op_sleep = 4'h7;
    typedef struct packed {
        logic [3:0] op;
        logic [6:0] fa;
        logic d;
        logic [7:0] lit;
        logic [7:0] fv;
        logic [7:0] av;
        logic [2:0] st;
    } rsso_case_s;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    int miscompares = 0;
    int n_checks = 0;
    logic [31:0] wdt_seen;
    logic [1:0] rsp_seen;
    // st holds z, dc, c in bits 2..0
    rsso_case_s cases [13] = '{
        '{op_rot_r, 7'd5, 1'b1, 8'h00, 8'he7, 8'h11, 3'b110},
        '{op_rot_r, 7'd6, 1'b0, 8'h00, 8'h02, 8'h11, 3'b001},
        '{op_rot_l, 7'd7, 1'b0, 8'h00, 8'he6, 8'h22, 3'b000},
        '{op_rot_l, 7'd8, 1'b1, 8'h00, 8'h80, 8'h22, 3'b111},
        '{op_lit_sub, 7'd9, 1'b1, 8'h10, 8'h33, 8'h10, 3'b000},
        '{op_lit_sub, 7'd9, 1'b0, 8'h05, 8'h33, 8'h06, 3'b111},
        '{op_f_sub, 7'd127, 1'b1, 8'h00, 8'h23, 8'h14, 3'b000},
        '{op_f_sub, 7'd0, 1'b0, 8'h00, 8'h40, 8'h41, 3'b000},
        '{op_f_sub, 7'd1, 1'b1, 8'h00, 8'h5a, 8'h5a, 3'b000},
        '{op_sub_brw, 7'd2, 1'b1, 8'h00, 8'h10, 8'h0f, 3'b000},
        '{op_sub_brw, 7'd3, 1'b0, 8'h00, 8'h50, 8'h20, 3'b001},
        '{op_swap, 7'd4, 1'b1, 8'h00, 8'ha5, 8'h00, 3'b101},
        '{op_swap, 7'd4, 1'b0, 8'h00, 8'h3c, 8'h77, 3'b010}
    };
    rsso_core #(.PRE_W(5), .WDT_W(8)) dut_u (
        .CORE_CLK(core_clk), .RST_N(rst_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready)
    );
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    // ------------------------------------------------------------
    // bus tasks and comparison
    // ------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string m);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    // aw and w offered together; bready raised early, held to bvalid
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [1:0] er);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // no cycle count assumed: only the watchdog ends a stuck wait
        do begin
            @(posedge core_clk);
        end while (!(awready === 1'b1 && wready === 1'b1));
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do begin
            @(posedge core_clk);
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er}, "write response");
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        do begin
            @(posedge core_clk);
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] ed,
        input logic [1:0] er, input string m);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, ed, m);
        chk({30'h0, r}, {30'h0, er}, "read response");
    endtask
    // expected result worked out here, never read back from the design
    task automatic run_case(input rsso_case_s k);
        logic [8:0] df;
        logic [4:0] dl;
        logic [7:0] opnd, res, e_acc, e_f;
        logic b, nc, ndc, nz, to_acc;
        wr(REG_FPTR, {25'h0, k.fa}, 4'hf, RESP_OKAY);
        wr(REG_FDATA, {24'h0, k.fv}, 4'hf, RESP_OKAY);
        wr(REG_ACC, {24'h0, k.av}, 4'hf, RESP_OKAY);
        wr(REG_STATUS, {29'h0, k.st}, 4'h1, RESP_OKAY);
        opnd = (k.op == op_lit_sub) ? k.lit : k.fv;
        b = (k.op == op_sub_brw) ? ~k.st[0] : 1'b0;
        df = {1'b0, opnd} - {1'b0, k.av} - {8'h00, b};
        dl = {1'b0, opnd[3:0]} - {1'b0, k.av[3:0]} - {4'h0, b};
        res = df[7:0];
        nc = ~df[8];
        ndc = ~dl[4];
        nz = (res == 8'h00);
        if (k.op == op_rot_r || k.op == op_rot_l || k.op == op_swap) begin
            ndc = k.st[1];
            nz = k.st[2];
        end
        case (k.op)
            op_rot_r: begin
                res = {k.st[0], k.fv[7:1]};
                nc = k.fv[0];
            end
            op_rot_l: begin
                res = {k.fv[6:0], k.st[0]};
                nc = k.fv[7];
            end
            op_swap: begin
                res = {k.fv[3:0], k.fv[7:4]};
                nc = k.st[0];
            end
            default: ;
        endcase
        to_acc = (k.op == op_lit_sub) || (k.d == DEST_ACC);
        e_acc = to_acc ? res : k.av;
        e_f = to_acc ? k.fv : res;
        wr(REG_CMD, {12'h000, k.op, k.d, k.fa, k.lit}, 4'hf, RESP_OKAY);
        rdc(REG_ACC, {24'h0, e_acc}, RESP_OKAY,
            "acc");
        rdc(REG_STATUS, {27'h0, 2'b11, nz, ndc, nc}, RESP_OKAY,
            "flags");
        rdc(REG_FDATA, {24'h0, e_f}, RESP_OKAY, "file");
    endtask
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        $display("FAIL %0t run did not finish", $time);
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rdc(REG_ACC, 32'h0, RESP_OKAY, "acc after reset");
        rdc(REG_STATUS, 32'h18, RESP_OKAY, "status after reset");
        rdc(REG_FPTR, 32'h0, RESP_OKAY, "pointer after reset");
        rdc(REG_FDATA, 32'h0, RESP_OKAY, "file after reset");
        foreach (cases[i]) begin
            run_case(cases[i]);
        end
        // refused commands leave acc and file alone
        wr(REG_CMD, {12'h000, 4'h0, 1'b0, 7'd4, 8'h00}, 4'hf, RESP_SLVERR);
        wr(REG_CMD, {12'h000, 4'h8, 1'b0, 7'd4, 8'h00}, 4'hf, RESP_SLVERR);
        wr(REG_CMD, {12'h000, op_swap, 1'b0, 7'd4, 8'h00}, 4'h3, RESP_OKAY);
        rdc(REG_ACC, 32'hc3, RESP_OKAY, "acc after refused");
        rdc(REG_FDATA, 32'h3c, RESP_OKAY, "file after refused");
        rdc(REG_CMD, 32'h0, RESP_OKAY, "command reads zero");
        rdc(8'h18, 32'h0, RESP_SLVERR, "unmapped read");
        wr(8'h18, 32'h5, 4'hf, RESP_SLVERR);
        // power-down and time-out bits are read-only
        // zeros written to the read-only bits must not clear them
        wr(REG_STATUS, 32'h00000007, 4'h1, RESP_OKAY);
        rdc(REG_STATUS, 32'h1f, RESP_OKAY, "status read-only bits");
        rd(REG_WDT, wdt_seen, rsp_seen);
        chk({30'h0, rsp_seen}, {30'h0, RESP_OKAY}, "watchdog response");
        n_checks++;
        if ($isunknown(wdt_seen) || wdt_seen == 32'h0) begin
            miscompares++;
            $display("FAIL %0t watchdog did not count", $time);
        end
        wr(REG_CMD, {12'h000, op_sleep, 16'h0000}, 4'hf, RESP_OKAY);
        rdc(REG_STATUS, 32'h17, RESP_OKAY, "status after sleep");
        wr(REG_STATUS, 32'h0000001f, 4'h1, RESP_OKAY);
        rdc(REG_STATUS, 32'h17, RESP_OKAY, "powerdown stays clear");
        rdc(REG_WDT, 32'h0, RESP_OKAY, "watchdog after sleep");
        report_and_stop();
    end
endmodule
`default_nettype wire
